// File: include/slf_defines.svh
// constants shared by the store-to-load forwarding check block
// assumes byte addresses of SLF_ADDR_W bits and store data of at most 16 bytes
`ifndef SLF_DEFINES_SVH
`define SLF_DEFINES_SVH

// ****************************************
// widths and geometry
// ****************************************
`define SLF_ADDR_W 48
`define SLF_DATA_W 128
`define SLF_SB_DEPTH 8
`define SLF_BANK_LSB 4
`define SLF_BANK_MSB 11
`define SLF_PAGE_LSB 12
`define SLF_QW_BITS 64
`define SLF_QW_BYTES 5'h08
`define SLF_UPPER_QW_OFS 4'h8

// ****************************************
// operand byte counts and alignment masks
// ****************************************
`define SLF_NB_BYTE 5'h01
`define SLF_NB_WORD 5'h02
`define SLF_NB_DWORD 5'h04
`define SLF_NB_QWORD 5'h08
`define SLF_NB_TBYTE 5'h0A
`define SLF_NB_DQWORD 5'h10
`define SLF_AM_BYTE 4'h0
`define SLF_AM_WORD 4'h1
`define SLF_AM_DWORD 4'h3
`define SLF_AM_QWORD 4'h7
`define SLF_AM_TBYTE 4'h7
`define SLF_AM_DQWORD 4'hF

`endif

// File: include/slf_pkg.sv
// types of the store-to-load forwarding check block
// uses nothing from slf_defines.svh; the enum encodings are written out here
package slf_pkg;

   typedef enum logic [2:0] {
      SLF_SZ_BYTE = 3'h0,
      SLF_SZ_WORD = 3'h1,
      SLF_SZ_DWORD = 3'h2,
      SLF_SZ_QWORD = 3'h3,
      SLF_SZ_TBYTE = 3'h4,
      SLF_SZ_DQWORD = 3'h5
   } slf_size_t;

   typedef enum logic [5:0] {
      SLF_LD_IDLE = 6'h01,
      SLF_LD_PENALTY = 6'h02,
      SLF_LD_STAGE1 = 6'h04,
      SLF_LD_STAGE2 = 6'h08,
      SLF_LD_DRAIN = 6'h10,
      SLF_LD_CACHE = 6'h20
   } slf_ld_state_t;

endpackage

// File: rtl/slf_align_chk.sv
// natural alignment check and byte count of one access
// assumes a size code from slf_pkg and the low four address bits
`timescale 1ns/1ns
`include "slf_defines.svh"
module slf_align_chk (
   // access
   input wire slf_pkg::slf_size_t size_i,
   input wire logic [3:0] addr_lo_i,
   // result
   output logic misal_o,
   output logic [4:0] nbytes_o
);
   import slf_pkg::*;

   logic [3:0] amask;

   always_comb begin
      case (size_i)
         SLF_SZ_BYTE: begin
            amask = `SLF_AM_BYTE;
            nbytes_o = `SLF_NB_BYTE;
         end
         SLF_SZ_WORD: begin
            amask = `SLF_AM_WORD;
            nbytes_o = `SLF_NB_WORD;
         end
         SLF_SZ_DWORD: begin
            amask = `SLF_AM_DWORD;
            nbytes_o = `SLF_NB_DWORD;
         end
         SLF_SZ_QWORD: begin
            amask = `SLF_AM_QWORD;
            nbytes_o = `SLF_NB_QWORD;
         end
         SLF_SZ_TBYTE: begin
            // ten-byte objects only need quadword alignment
            amask = `SLF_AM_TBYTE;
            nbytes_o = `SLF_NB_TBYTE;
         end
         default: begin
            amask = `SLF_AM_DQWORD;
            nbytes_o = `SLF_NB_DQWORD;
         end
      endcase
   end

   assign misal_o = |(addr_lo_i & amask);
endmodule

// File: rtl/slf_match_cmp.sv
// compares one store-buffer entry against the load being checked
// assumes both accesses span at most two adjacent 16-byte banks
`timescale 1ns/1ns
`include "slf_defines.svh"
module slf_match_cmp #(
   parameter int ADDR_W = `SLF_ADDR_W
) (
   // store entry
   input wire logic [ADDR_W-1:0] st_addr_i,
   input wire slf_pkg::slf_size_t st_size_i,
   // load
   input wire logic [ADDR_W-1:0] ld_addr_i,
   input wire logic [4:0] ld_nbytes_i,
   // compare results
   output logic stage1_hit_o,
   output logic stage2_hit_o,
   output logic same_start_o,
   output logic upper_qw_o,
   output logic st_misal_o,
   output logic st_narrow_o,
   output logic [4:0] st_nbytes_o
);
   import slf_pkg::*;

   // ****************************************
   // dword masks over own bank and the next
   // ****************************************
   logic [4:0] st_end;
   logic [4:0] ld_end;
   logic [7:0] st_dmask;
   logic [7:0] ld_dmask;
   logic [7:0] st_bank;
   logic [7:0] ld_bank;
   logic same_bank;
   logic st_below;
   logic ld_below;

   slf_align_chk u_st_align (
      .size_i(st_size_i),
      .addr_lo_i(st_addr_i[3:0]),
      .misal_o(st_misal_o),
      .nbytes_o(st_nbytes_o)
   );

   assign st_end = {1'b0, st_addr_i[3:0]} + st_nbytes_o - 5'h01;
   assign ld_end = {1'b0, ld_addr_i[3:0]} + ld_nbytes_i - 5'h01;

   genvar d;
   generate
      for (d = 0; d < 8; d++) begin : g_dw
         assign st_dmask[d] = (3'(d) >= {1'b0, st_addr_i[3:2]}) && (3'(d) <= st_end[4:2]);
         assign ld_dmask[d] = (3'(d) >= {1'b0, ld_addr_i[3:2]}) && (3'(d) <= ld_end[4:2]);
      end
   endgenerate

   // bank index wraps at 4K on purpose: the aliasing is caught by the second stage
   assign st_bank = st_addr_i[`SLF_BANK_MSB:`SLF_BANK_LSB];
   assign ld_bank = ld_addr_i[`SLF_BANK_MSB:`SLF_BANK_LSB];
   assign same_bank = (st_bank == ld_bank) && |(st_dmask[3:0] & ld_dmask[3:0]);
   assign st_below = (8'(st_bank + 8'h01) == ld_bank) && |(st_dmask[7:4] & ld_dmask[3:0]);
   assign ld_below = (8'(ld_bank + 8'h01) == st_bank) && |(ld_dmask[7:4] & st_dmask[3:0]);

   assign stage1_hit_o = same_bank || st_below || ld_below;
   assign stage2_hit_o = st_addr_i[ADDR_W-1:`SLF_PAGE_LSB] == ld_addr_i[ADDR_W-1:`SLF_PAGE_LSB];
   assign same_start_o = st_addr_i == ld_addr_i;
   assign upper_qw_o = (st_size_i == SLF_SZ_DQWORD) && !st_misal_o && (ld_nbytes_i <= `SLF_QW_BYTES)
                       && (ld_addr_i == {st_addr_i[ADDR_W-1:4], `SLF_UPPER_QW_OFS});
   assign st_narrow_o = (st_size_i == SLF_SZ_BYTE) || (st_size_i == SLF_SZ_WORD);
endmodule

// File: rtl/slf_forward_check.sv
// store buffer with store-to-load forwarding check, retire-gated commit and cache fallback
// assumes loads enter in program order after the stores already accepted,
// the cache returns load data in the low bytes, and a cache write is visible next cycle
`timescale 1ns/1ns
`include "slf_defines.svh"
module slf_forward_check #(
   parameter int ADDR_W = `SLF_ADDR_W,
   parameter int DATA_W = `SLF_DATA_W,
   parameter int DEPTH = `SLF_SB_DEPTH
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // control
   input wire logic align_mask_en_i,
   // store issue
   input wire logic st_valid_i,
   input wire logic [ADDR_W-1:0] st_addr_i,
   input wire slf_pkg::slf_size_t st_size_i,
   input wire logic [DATA_W-1:0] st_data_i,
   output logic st_ready_o,
   output logic st_align_fault_o,
   // reorder buffer retire
   input wire logic rob_store_retire_i,
   // load issue and answer
   input wire logic ld_valid_i,
   input wire logic [ADDR_W-1:0] ld_addr_i,
   input wire slf_pkg::slf_size_t ld_size_i,
   output logic ld_ready_o,
   output logic ld_done_o,
   output logic [DATA_W-1:0] ld_data_o,
   output logic ld_forwarded_o,
   output logic ld_retry_o,
   output logic ld_align_fault_o,
   // data cache write
   output logic dc_wr_valid_o,
   output logic [ADDR_W-1:0] dc_wr_addr_o,
   output slf_pkg::slf_size_t dc_wr_size_o,
   output logic [DATA_W-1:0] dc_wr_data_o,
   input wire logic dc_wr_ready_i,
   // data cache read
   output logic dc_rd_req_o,
   output logic [ADDR_W-1:0] dc_rd_addr_o,
   input wire logic dc_rd_valid_i,
   input wire logic [DATA_W-1:0] dc_rd_data_i
);
   import slf_pkg::*;

   localparam int PTR_W = $clog2(DEPTH);

   // ****************************************
   // state
   // ****************************************
   logic [DEPTH-1:0] sb_valid_q;
   logic [DEPTH-1:0] sb_retired_q;
   logic [DEPTH-1:0] sb_older_q;
   logic [ADDR_W-1:0] sb_addr_q [DEPTH];
   slf_size_t sb_size_q [DEPTH];
   logic [DATA_W-1:0] sb_data_q [DEPTH];
   logic [PTR_W-1:0] head_q;
   logic [PTR_W-1:0] tail_q;
   logic [PTR_W-1:0] ret_ptr_q;
   logic [PTR_W:0] count_q;
   logic st_ready_q;
   logic st_fault_q;
   slf_ld_state_t state_q;
   slf_ld_state_t state_d;
   logic [ADDR_W-1:0] ld_addr_q;
   logic [4:0] ld_nbytes_q;
   logic ld_misal_q;
   logic [PTR_W-1:0] sel_q;
   logic ld_ready_q;
   logic ld_done_q;
   logic [DATA_W-1:0] ld_data_q;
   logic ld_fwd_q;
   logic ld_retry_q;
   logic ld_fault_q;
   logic dc_wr_valid_q;
   logic [ADDR_W-1:0] dc_wr_addr_q;
   slf_size_t dc_wr_size_q;
   logic [DATA_W-1:0] dc_wr_data_q;
   logic dc_rd_req_q;

   // ****************************************
   // store side
   // ****************************************
   logic st_in_misal;
   logic ld_in_misal;
   logic [4:0] ld_in_nbytes;
   logic st_take;
   logic alloc;
   logic pop;
   logic wr_start;
   logic retire_mark;
   logic [PTR_W:0] count_d;

   slf_align_chk u_st_in_align (
      .size_i(st_size_i),
      .addr_lo_i(st_addr_i[3:0]),
      .misal_o(st_in_misal),
      .nbytes_o()
   );

   slf_align_chk u_ld_in_align (
      .size_i(ld_size_i),
      .addr_lo_i(ld_addr_i[3:0]),
      .misal_o(ld_in_misal),
      .nbytes_o(ld_in_nbytes)
   );

   // a faulting store is taken off the port but never enters the buffer
   assign st_take = st_valid_i && st_ready_q;
   assign alloc = st_take && !(align_mask_en_i && st_in_misal);
   assign pop = dc_wr_valid_q && dc_wr_ready_i;
   assign wr_start = sb_valid_q[head_q] && sb_retired_q[head_q] && !dc_wr_valid_q;
   assign retire_mark = rob_store_retire_i && sb_valid_q[ret_ptr_q] && !sb_retired_q[ret_ptr_q];
   assign count_d = (PTR_W+1)'(count_q + {{PTR_W{1'b0}}, alloc} - {{PTR_W{1'b0}}, pop});

   // ****************************************
   // per-entry compare
   // ****************************************
   logic ld_take;
   logic [DEPTH-1:0] elig;
   logic [DEPTH-1:0] hit1;
   logic [DEPTH-1:0] hit2;
   logic [DEPTH-1:0] same_start;
   logic [DEPTH-1:0] upper_qw;
   logic [DEPTH-1:0] e_misal;
   logic [DEPTH-1:0] e_narrow;
   logic [DEPTH-1:0] split;
   logic [4:0] e_nbytes [DEPTH];

   assign ld_take = ld_valid_i && ld_ready_q;
   assign elig = sb_valid_q & sb_older_q;

   genvar i;
   generate
      for (i = 0; i < DEPTH; i++) begin : g_ent
         slf_match_cmp #(
            .ADDR_W(ADDR_W)
         ) u_cmp (
            .st_addr_i(sb_addr_q[i]),
            .st_size_i(sb_size_q[i]),
            .ld_addr_i(ld_addr_q),
            .ld_nbytes_i(ld_nbytes_q),
            .stage1_hit_o(hit1[i]),
            .stage2_hit_o(hit2[i]),
            .same_start_o(same_start[i]),
            .upper_qw_o(upper_qw[i]),
            .st_misal_o(e_misal[i]),
            .st_narrow_o(e_narrow[i]),
            .st_nbytes_o(e_nbytes[i])
         );

         // another narrow store to different bytes of the selected store's doubleword
         assign split[i] = elig[i] && e_narrow[i] && (PTR_W'(i) != sel_q)
                           && (sb_addr_q[i][ADDR_W-1:2] == sb_addr_q[sel_q][ADDR_W-1:2])
                           && ((sb_addr_q[i][1:0] != sb_addr_q[sel_q][1:0])
                               || (sb_size_q[i] != sb_size_q[sel_q]));

         always_ff @(posedge core_clk_i) begin
            if (!reset_n_i) begin
               sb_valid_q[i] <= 1'b0;
               sb_retired_q[i] <= 1'b0;
               sb_older_q[i] <= 1'b0;
            end else begin
               if (alloc && tail_q == PTR_W'(i)) begin
                  sb_valid_q[i] <= 1'b1;
                  sb_retired_q[i] <= 1'b0;
                  sb_older_q[i] <= 1'b0;
               end else begin
                  if (pop && head_q == PTR_W'(i)) begin
                     sb_valid_q[i] <= 1'b0;
                  end
                  if (retire_mark && ret_ptr_q == PTR_W'(i)) begin
                     sb_retired_q[i] <= 1'b1;
                  end
                  if (ld_take) begin
                     sb_older_q[i] <= sb_valid_q[i];
                  end
               end
            end
         end

         always_ff @(posedge core_clk_i) begin
            if (alloc && tail_q == PTR_W'(i)) begin
               sb_addr_q[i] <= st_addr_i;
               sb_size_q[i] <= st_size_i;
               sb_data_q[i] <= st_data_i;
            end
         end
      end
   endgenerate

   // ****************************************
   // youngest stage-one match
   // ****************************************
   logic any_hit1;
   logic [PTR_W-1:0] sel_d;

   always_comb begin
      logic [PTR_W-1:0] best_age;
      logic [PTR_W-1:0] age;
      best_age = '0;
      age = '0;
      any_hit1 = 1'b0;
      sel_d = '0;
      for (int k = 0; k < DEPTH; k++) begin
         age = PTR_W'(PTR_W'(k) - head_q);
         if (elig[k] && hit1[k] && (!any_hit1 || age >= best_age)) begin
            any_hit1 = 1'b1;
            best_age = age;
            sel_d = PTR_W'(k);
         end
      end
   end

   // ****************************************
   // forwarding decision on the selected entry
   // ****************************************
   logic fwd_ok;
   logic [DATA_W-1:0] fwd_raw;
   logic [DATA_W-1:0] byte_keep;

   assign fwd_ok = !ld_misal_q && !e_misal[sel_q]
                   && (ld_nbytes_q <= e_nbytes[sel_q])
                   && (same_start[sel_q] || upper_qw[sel_q])
                   && !(e_narrow[sel_q] && |split);
   assign fwd_raw = upper_qw[sel_q] ? (sb_data_q[sel_q] >> `SLF_QW_BITS) : sb_data_q[sel_q];

   generate
      for (i = 0; i < DATA_W / 8; i++) begin : g_keep
         assign byte_keep[i*8 +: 8] = {8{5'(i) < ld_nbytes_q}};
      end
   endgenerate

   // ****************************************
   // load state machine
   // ****************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         SLF_LD_IDLE: begin
            if (ld_take && ld_in_misal && align_mask_en_i) begin
               state_d = SLF_LD_IDLE;
            end else if (ld_take && ld_in_misal) begin
               state_d = SLF_LD_PENALTY;
            end else if (ld_take) begin
               state_d = SLF_LD_STAGE1;
            end
         end
         SLF_LD_PENALTY: begin
            state_d = SLF_LD_STAGE1;
         end
         SLF_LD_STAGE1: begin
            state_d = any_hit1 ? SLF_LD_STAGE2 : SLF_LD_CACHE;
         end
         SLF_LD_STAGE2: begin
            if (!elig[sel_q]) begin
               state_d = SLF_LD_STAGE1;
            end else if (hit2[sel_q] && fwd_ok) begin
               state_d = SLF_LD_IDLE;
            end else begin
               state_d = SLF_LD_DRAIN;
            end
         end
         SLF_LD_DRAIN: begin
            // the whole match starts over once the blocking store has reached the cache
            if (!elig[sel_q]) begin
               state_d = SLF_LD_STAGE1;
            end
         end
         SLF_LD_CACHE: begin
            if (dc_rd_valid_i) begin
               state_d = SLF_LD_IDLE;
            end
         end
         default: begin
            state_d = SLF_LD_IDLE;
         end
      endcase
   end

   logic fwd_done;
   logic cache_done;
   logic fault_done;

   assign fwd_done = (state_q == SLF_LD_STAGE2) && elig[sel_q] && hit2[sel_q] && fwd_ok;
   assign cache_done = (state_q == SLF_LD_CACHE) && dc_rd_valid_i;
   assign fault_done = (state_q == SLF_LD_IDLE) && ld_take && ld_in_misal && align_mask_en_i;

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         state_q <= SLF_LD_IDLE;
         ld_ready_q <= 1'b0;
         ld_addr_q <= '0;
         ld_nbytes_q <= '0;
         ld_misal_q <= 1'b0;
         sel_q <= '0;
      end else begin
         state_q <= state_d;
         ld_ready_q <= state_d == SLF_LD_IDLE;
         if (ld_take) begin
            ld_addr_q <= ld_addr_i;
            ld_nbytes_q <= ld_in_nbytes;
            ld_misal_q <= ld_in_misal;
         end
         if (state_q == SLF_LD_STAGE1) begin
            sel_q <= sel_d;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         ld_done_q <= 1'b0;
         ld_data_q <= '0;
         ld_fwd_q <= 1'b0;
         ld_retry_q <= 1'b0;
         ld_fault_q <= 1'b0;
         dc_rd_req_q <= 1'b0;
      end else begin
         ld_done_q <= fwd_done || cache_done || fault_done;
         ld_fwd_q <= fwd_done;
         ld_fault_q <= fault_done;
         ld_retry_q <= (state_q == SLF_LD_STAGE2) && elig[sel_q] && !hit2[sel_q];
         dc_rd_req_q <= (state_q == SLF_LD_STAGE1) && !any_hit1;
         if (fwd_done) begin
            ld_data_q <= fwd_raw & byte_keep;
         end else if (cache_done) begin
            ld_data_q <= dc_rd_data_i & byte_keep;
         end
      end
   end

   // ****************************************
   // buffer pointers and cache commit
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         head_q <= '0;
         tail_q <= '0;
         ret_ptr_q <= '0;
         count_q <= '0;
         st_ready_q <= 1'b0;
         st_fault_q <= 1'b0;
      end else begin
         head_q <= pop ? PTR_W'(head_q + 1'b1) : head_q;
         tail_q <= alloc ? PTR_W'(tail_q + 1'b1) : tail_q;
         ret_ptr_q <= retire_mark ? PTR_W'(ret_ptr_q + 1'b1) : ret_ptr_q;
         count_q <= count_d;
         // a misaligned store holds the port for one extra cycle
         st_ready_q <= (count_d < (PTR_W+1)'(DEPTH)) && !(st_take && st_in_misal);
         st_fault_q <= st_take && st_in_misal && align_mask_en_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!reset_n_i) begin
         dc_wr_valid_q <= 1'b0;
         dc_wr_addr_q <= '0;
         dc_wr_size_q <= SLF_SZ_BYTE;
         dc_wr_data_q <= '0;
      end else if (wr_start) begin
         dc_wr_valid_q <= 1'b1;
         dc_wr_addr_q <= sb_addr_q[head_q];
         dc_wr_size_q <= sb_size_q[head_q];
         dc_wr_data_q <= sb_data_q[head_q];
      end else if (pop) begin
         dc_wr_valid_q <= 1'b0;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign st_ready_o = st_ready_q;
   assign st_align_fault_o = st_fault_q;
   assign ld_ready_o = ld_ready_q;
   assign ld_done_o = ld_done_q;
   assign ld_data_o = ld_data_q;
   assign ld_forwarded_o = ld_fwd_q;
   assign ld_retry_o = ld_retry_q;
   assign ld_align_fault_o = ld_fault_q;
   assign dc_wr_valid_o = dc_wr_valid_q;
   assign dc_wr_addr_o = dc_wr_addr_q;
   assign dc_wr_size_o = dc_wr_size_q;
   assign dc_wr_data_o = dc_wr_data_q;
   assign dc_rd_req_o = dc_rd_req_q;
   assign dc_rd_addr_o = ld_addr_q;
endmodule

// File: bench/slf_fwd_chk.sv
// assertions on the ports of slf_forward_check
// assumes it is bound to that module and that loads run one at a time
`timescale 1ns/1ns
module slf_fwd_chk (
   // clock, reset, control
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   input wire logic align_mask_en_i,
   // store side
   input wire logic st_valid_i,
   input wire logic [47:0] st_addr_i,
   input wire slf_pkg::slf_size_t st_size_i,
   input wire logic st_ready_o,
   input wire logic st_align_fault_o,
   input wire logic rob_store_retire_i,
   // load side
   input wire logic ld_valid_i,
   input wire logic [47:0] ld_addr_i,
   input wire slf_pkg::slf_size_t ld_size_i,
   input wire logic ld_ready_o,
   input wire logic ld_done_o,
   input wire logic ld_forwarded_o,
   input wire logic ld_retry_o,
   input wire logic ld_align_fault_o,
   // cache side
   input wire logic dc_wr_valid_o,
   input wire logic [47:0] dc_wr_addr_o,
   input wire logic dc_wr_ready_i,
   input wire logic dc_rd_valid_i
);
   import slf_pkg::*;
   logic [3:0] la_q;
   slf_size_t ls_q;
   int unsigned rc_q;
   wire ld_go = ld_valid_i && ld_ready_o;
   wire st_go = st_valid_i && st_ready_o;
   // ****************************************
   // helpers
   // ****************************************
   function automatic logic mis(slf_size_t s, logic [3:0] a);
      return |(a & ((s == SLF_SZ_TBYTE) ? 4'h7 : 4'((1 << s) - 1)));
   endfunction
   // retired stores not yet written; a write with none pending is early
   always_ff @(posedge core_clk_i) begin
      if (ld_go) begin
         la_q <= ld_addr_i[3:0];
         ls_q <= ld_size_i;
      end
      if (!reset_n_i) rc_q <= 0;
      else rc_q <= rc_q + rob_store_retire_i - (dc_wr_valid_o && dc_wr_ready_i);
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!reset_n_i);
   // ****************************************
   // properties
   // ****************************************
   a_fwd_aligned: assert property (ld_forwarded_o |-> ld_done_o && !mis(ls_q, la_q))
      else $error("misaligned load forwarded");
   a_ld_fault: assert property (ld_go && align_mask_en_i && mis(ld_size_i, ld_addr_i[3:0])
      |=> ld_done_o && ld_align_fault_o && !ld_forwarded_o) else $error("load fault missing");
   a_st_fault: assert property (st_go && align_mask_en_i && mis(st_size_i, st_addr_i[3:0])
      |=> st_align_fault_o) else $error("store fault missing");
   a_st_penalty: assert property (st_go && mis(st_size_i, st_addr_i[3:0]) |=> !st_ready_o)
      else $error("no misalign penalty");
   a_ld_penalty: assert property (ld_go && !align_mask_en_i && mis(ld_size_i, ld_addr_i[3:0]) |=> !ld_done_o[*3])
      else $error("no load misalign penalty");
   a_wr_hold: assert property (dc_wr_valid_o && !dc_wr_ready_i |=> dc_wr_valid_o && $stable(dc_wr_addr_o))
      else $error("write dropped");
   a_wr_retired: assert property (dc_wr_valid_o |-> rc_q != 0) else $error("write before retire");
   a_retry_cancel: assert property (ld_retry_o |-> !ld_done_o && !ld_ready_o)
      else $error("retry answered");
   a_rd_answer: assert property (dc_rd_valid_i |=> ld_done_o && !ld_forwarded_o)
      else $error("cache data lost");
   c_fwd: cover property (ld_forwarded_o);
   c_retry: cover property (ld_retry_o);
   c_wr_stall: cover property (dc_wr_valid_o && !dc_wr_ready_i);
endmodule
bind slf_forward_check slf_fwd_chk slf_fwd_chk_i (.*);

// File: bench/slf_core_model.sv
// data cache partner of the forwarding block
// assumes memory reads as zero until written
`timescale 1ns/1ns
module slf_core_model (
   // clock and pace
   input wire logic clk_i,
   input wire logic slow_i,
   // cache write
   input wire logic wr_valid_i,
   input wire logic [47:0] wr_addr_i,
   input wire slf_pkg::slf_size_t wr_size_i,
   input wire logic [127:0] wr_data_i,
   output logic wr_ready_o,
   // cache read
   input wire logic rd_req_i,
   input wire logic [47:0] rd_addr_i,
   output logic rd_valid_o,
   output logic [127:0] rd_data_o
);
   import slf_pkg::*;
   logic [7:0] mem [logic [47:0]];
   int wait_q = 0;
   initial begin
      wr_ready_o = 1'b0;
      rd_valid_o = 1'b0;
      rd_data_o = '0;
   end
   // slow: writes stall every other cycle, reads answer late
   always @(posedge clk_i) begin
      rd_valid_o <= 1'b0;
      // an idle read bus keeps changing so stale data never looks right
      rd_data_o <= ~rd_data_o;
      wr_ready_o <= !slow_i || !wr_ready_o;
      if (wr_valid_i && wr_ready_o)
         for (int k = 0; k < ((wr_size_i == SLF_SZ_TBYTE) ? 10 : (1 << wr_size_i)); k++)
            mem[wr_addr_i + 48'(k)] = wr_data_i[8*k +: 8];
      if (wait_q == 1) begin
         rd_valid_o <= 1'b1;
         for (int k = 0; k < 16; k++)
            rd_data_o[8*k +: 8] <= mem.exists(rd_addr_i + 48'(k)) ? mem[rd_addr_i + 48'(k)] : 8'h00;
      end
      wait_q <= rd_req_i ? (slow_i ? 4 : 1) : (wait_q > 0 ? wait_q - 1 : 0);
   end
endmodule

// File: bench/tb.sv
// self-checking bench of slf_forward_check with a cache model
// assumes the package and design files are compiled first
`timescale 1ns/1ns
module tb;
   import slf_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, msk = 1'b0, slow = 1'b0, sv = 1'b0, ret = 1'b0, lv = 1'b0, seen_rty = 1'b0;
   logic [47:0] sa = '0, la = '0, wa, ra;
   slf_size_t ss = SLF_SZ_BYTE, ls = SLF_SZ_BYTE, wsz;
   logic [127:0] sd = '0, ldat, wd, rd;
   logic [129:0] res;
   logic s_rdy, s_flt, l_rdy, l_done, l_fwd, l_rty, l_flt, wv, w_rdy, rq, rv;
   int fails = 0, total_checks = 0;
   always #2 clk = ~clk;
   always @(posedge clk) if (l_rty === 1'b1) seen_rty <= 1'b1;
   slf_forward_check slf_forward_check_i (.core_clk_i(clk), .reset_n_i(rst_n), .align_mask_en_i(msk),
      .st_valid_i(sv), .st_addr_i(sa), .st_size_i(ss), .st_data_i(sd), .st_ready_o(s_rdy),
      .st_align_fault_o(s_flt), .rob_store_retire_i(ret), .ld_valid_i(lv), .ld_addr_i(la), .ld_size_i(ls),
      .ld_ready_o(l_rdy), .ld_done_o(l_done), .ld_data_o(ldat), .ld_forwarded_o(l_fwd), .ld_retry_o(l_rty),
      .ld_align_fault_o(l_flt), .dc_wr_valid_o(wv), .dc_wr_addr_o(wa), .dc_wr_size_o(wsz),
      .dc_wr_data_o(wd), .dc_wr_ready_i(w_rdy), .dc_rd_req_o(rq), .dc_rd_addr_o(ra),
      .dc_rd_valid_i(rv), .dc_rd_data_i(rd));
   slf_core_model slf_core_model_i (.clk_i(clk), .slow_i(slow), .wr_valid_i(wv), .wr_addr_i(wa),
      .wr_size_i(wsz), .wr_data_i(wd), .wr_ready_o(w_rdy), .rd_req_i(rq), .rd_addr_i(ra),
      .rd_valid_o(rv), .rd_data_o(rd));
   // ****************************************
   // port tasks
   // ****************************************
   task automatic chk(input logic [129:0] g, input logic [129:0] e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic st(input logic [47:0] a, input slf_size_t s, input logic [127:0] d);
      @(negedge clk);
      sv = 1'b1;
      sa = a;
      ss = s;
      sd = d;
      do @(posedge clk); while (s_rdy !== 1'b1);
      @(negedge clk);
      sv = 1'b0;
   endtask
   // answer kept as fault, forwarded flag and data
   task automatic ld(input logic [47:0] a, input slf_size_t s);
      @(negedge clk);
      lv = 1'b1;
      la = a;
      ls = s;
      do @(posedge clk); while (l_rdy !== 1'b1);
      @(negedge clk);
      lv = 1'b0;
      while (l_done !== 1'b1) @(negedge clk);
      res = {l_flt, l_fwd, ldat};
   endtask
   task automatic rt(input int n);
      repeat (n) begin
         @(negedge clk);
         ret = 1'b1;
         @(negedge clk);
         ret = 1'b0;
      end
   endtask
   // a refused load only finishes once the core retires the stores
   task automatic ldw(input logic [47:0] a, input slf_size_t s, input int n);
      fork
         ld(a, s);
         begin
            repeat (8) @(posedge clk);
            rt(n);
         end
      join
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_fwd;
      st(48'h100, SLF_SZ_DWORD, 128'h11223344);
      ld(48'h100, SLF_SZ_WORD);
      chk(res, {2'b01, 128'h3344});
      ldw(48'h100, SLF_SZ_QWORD, 1);
      chk(res, {2'b00, 128'h11223344});
      st(48'h200, SLF_SZ_DQWORD, {64'hA1A2A3A4A5A6A7A8, 64'hB1B2B3B4B5B6B7B8});
      ld(48'h208, SLF_SZ_QWORD);
      chk(res, {2'b01, 64'h0, 64'hA1A2A3A4A5A6A7A8});
      ldw(48'h204, SLF_SZ_DWORD, 1);
      chk(res, {2'b00, 96'h0, 32'hB1B2B3B4});
      $display("t_fwd end");
   endtask
   task automatic t_align;
      logic [3:0] m;
      msk = 1'b1;
      for (int s = 1; s < 6; s++) begin
         m = (s == 4) ? 4'h7 : 4'((1 << s) - 1);
         ld(48'h300 + m + 1, slf_size_t'(s));
         chk(res[129], 1'b0);
         ld(48'h300 + (m + 1) / 2, slf_size_t'(s));
         chk(res[129], 1'b1);
      end
      st(48'h302, SLF_SZ_DWORD, 128'hFF);
      chk(s_flt, 1'b1);
      msk = 1'b0;
      st(48'h404, SLF_SZ_QWORD, 128'h8877665544332211);
      ldw(48'h404, SLF_SZ_QWORD, 1);
      chk(res, {2'b00, 128'h8877665544332211});
      $display("t_align end");
   endtask
   task automatic t_split;
      slow = 1'b1;
      // the same-start store is the youngest, so only the split test can refuse it
      st(48'h501, SLF_SZ_BYTE, 128'hC3);
      st(48'h500, SLF_SZ_BYTE, 128'h5A);
      ldw(48'h500, SLF_SZ_BYTE, 2);
      chk(res, {2'b00, 128'h5A});
      st(48'h510, SLF_SZ_BYTE, 128'h96);
      ld(48'h510, SLF_SZ_BYTE);
      chk(res, {2'b01, 128'h96});
      rt(1);
      slow = 1'b0;
      st(48'h600, SLF_SZ_DWORD, 128'h01020304);
      st(48'h600, SLF_SZ_DWORD, 128'h0A0B0C0D);
      ld(48'h600, SLF_SZ_DWORD);
      chk(res, {2'b01, 128'h0A0B0C0D});
      rt(2);
      st(48'h1040, SLF_SZ_DWORD, 128'h77);
      ldw(48'h2040, SLF_SZ_DWORD, 1);
      chk(res, {2'b00, 128'h0});
      chk(seen_rty, 1'b1);
      $display("t_split end");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      rst_n = 1'b1;
      t_fwd;
      t_align;
      t_split;
      repeat (20) @(negedge clk);
      finish_test;
   end
   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      finish_test;
   end
endmodule
